// ==== rtl/fbs_top.sv ====
// fieldbus sensor data slave: parameters, averaging, telegram, address and led
`timescale 1ns/1ps
module fbs_top #(
    parameter int TICK_CYC = fbs_pkg::TICK_CYC,
    parameter int LED_HALF_CYC = fbs_pkg::LED_HALF_CYC,
    parameter logic [15:0] TEMP_LO = fbs_pkg::TEMP_LO_DEF,
    parameter logic [15:0] TEMP_HI = fbs_pkg::TEMP_HI_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_valid,
    input wire logic [15:0] core_temp,
    input wire logic [31:0] core_vel,
    input wire logic [9:0] core_flags,
    input wire logic fb_online,
    input wire logic fb_error,
    input wire logic tel_rd,
    input wire logic [3:0] tel_idx,
    output logic [7:0] tel_data,
    output logic tel_ack,
    output logic data_ex,
    output logic prm_err,
    input wire logic [3:0] sw_tens,
    input wire logic [3:0] sw_ones,
    output logic [6:0] station_addr,
    output logic led_green,
    output logic led_red
);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic rdy;
        logic err;
        logic [31:0] rdata;
        logic [7:0] cfg_id;
        logic cfg_ok;
        logic prm_ok;
        logic prm_err;
        logic [7:0] stg_avg;
        logic [15:0] stg_diam;
        logic [7:0] avg;
        logic [15:0] diam;
        logic [7:0] vunit;
        logic [7:0] sref;
        logic [7:0] tunit;
        fbs_pkg::fbs_mode_t mode;
        logic dex;
        logic [7:0] sw1;
        logic [7:0] sw2;
        logic [6:0] addr;
        logic [25:0] tick;
        logic [23:0] led_cnt;
        logic blink;
        logic grn;
        logic red;
        logic [31:0] lvel;
        logic [15:0] ltmp;
        fbs_pkg::fbs_avg_t ast;
        logic [6:0] wp;
        logic [6:0] fill;
        logic [38:0] svel;
        logic [22:0] stmp;
        logic [5:0] step;
        logic [7:0] rv;
        logic [38:0] qv;
        logic [7:0] rt;
        logic [38:0] qt;
        logic tneg;
        logic [31:0] avel;
        logic [15:0] atmp;
        logic [31:0] vref;
        logic [15:0] tout;
        logic [15:0] status;
        logic [7:0] tdata;
        logic tack;
    } fbs_state_t;

    fbs_state_t s_q;
    fbs_state_t s_d;
    logic [47:0] mem_rdata;
    logic mem_we;
    logic [6:0] mem_raddr;
    logic [31:0] vol;

    // oldest sample of the window is read one cycle ahead of its use
    assign mem_we = (s_q.ast == fbs_pkg::A_UPD);
    assign mem_raddr = s_q.wp - s_q.avg[6:0];

    fbs_avg_mem #(
        .W(48),
        .AW(fbs_pkg::AVG_AW)
    ) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(mem_we),
        .waddr(s_q.wp),
        .wdata({s_q.lvel, s_q.ltmp}),
        .raddr(mem_raddr),
        .rdata_q(mem_rdata)
    );

    fbs_volume #(
        .PROFILE_Q16(fbs_pkg::PROFILE_DEF)
    ) u_vol (
        .pclk(pclk),
        .presetn(presetn),
        .vel(s_q.vref),
        .diam(s_q.diam),
        .unit(s_q.vunit[3:0]),
        .vol_q(vol)
    );

    // ********************************
    // next-state logic
    // ********************************
    always_comb begin
        logic [38:0] nsv;
        logic [22:0] nst;
        logic [7:0] tv;
        logic [7:0] tt;
        logic [48:0] vk;
        logic signed [34:0] tf;
        logic [95:0] tel;
        logic [95:0] sh;
        logic [3:0] len;
        logic [3:0] dt;
        logic [3:0] do1;
        logic prm_good;
        logic restart;
        nsv = '0;
        nst = '0;
        tv = '0;
        tt = '0;
        vk = '0;
        tf = '0;
        tel = '0;
        sh = '0;
        len = '0;
        dt = '0;
        do1 = '0;
        prm_good = 1'b0;
        restart = 1'b0;
        s_d = s_q;
        s_d.tack = 1'b0;

        // apb setup phase: decode and capture read data
        s_d.rdy = 1'b0;
        s_d.err = 1'b0;
        if (psel && !penable) begin
            s_d.rdy = 1'b1;
            case (paddr)
                fbs_pkg::OFF_CFG: s_d.rdata = {24'h000000, s_q.cfg_id};
                fbs_pkg::OFF_PRM0: s_d.rdata = {8'h00, s_q.diam, s_q.avg};
                fbs_pkg::OFF_PRM1: s_d.rdata = {8'h00, s_q.tunit, s_q.sref, s_q.vunit};
                fbs_pkg::OFF_STAT: s_d.rdata = {17'h00000, s_q.addr, 4'h0, s_q.prm_ok, s_q.cfg_ok, s_q.mode};
                fbs_pkg::OFF_DIAG: s_d.rdata = {8'h00, s_q.status, 7'h00, s_q.prm_err};
                fbs_pkg::OFF_TRNG: s_d.rdata = {TEMP_HI, TEMP_LO};
                default: begin
                    s_d.rdata = '0;
                    s_d.err = 1'b1;
                end
            endcase
        end

        // apb access phase: writes take effect at the completing edge
        if (psel && penable && s_q.rdy && pwrite && !s_q.err) begin
            case (paddr)
                fbs_pkg::OFF_CFG: begin
                    s_d.cfg_id = pwdata[7:0];
                    s_d.cfg_ok = (pwdata[7:0] == fbs_pkg::CFG_LONG) || (pwdata[7:0] == fbs_pkg::CFG_SHORT);
                end
                fbs_pkg::OFF_PRM0: begin
                    s_d.stg_avg = pwdata[7:0];
                    s_d.stg_diam = pwdata[23:8];
                end
                fbs_pkg::OFF_PRM1: begin
                    prm_good = (s_q.stg_avg <= fbs_pkg::AVG_MAX) && (s_q.stg_diam >= fbs_pkg::DIAM_MIN)
                        && (s_q.stg_diam <= fbs_pkg::DIAM_MAX) && (pwdata[7:0] < fbs_pkg::VUNIT_CNT)
                        && (pwdata[15:8] < fbs_pkg::SREF_CNT) && (pwdata[23:16] < fbs_pkg::TUNIT_CNT);
                    if (prm_good) begin
                        restart = (s_q.stg_avg != s_q.avg);
                        s_d.avg = s_q.stg_avg;
                        s_d.diam = s_q.stg_diam;
                        s_d.vunit = pwdata[7:0];
                        s_d.sref = pwdata[15:8];
                        s_d.tunit = pwdata[23:16];
                        s_d.prm_ok = 1'b1;
                        s_d.prm_err = 1'b0;
                    end else begin
                        s_d.prm_ok = 1'b0;
                        s_d.prm_err = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // link state; bit timing is recovered by the link engine, so no rate is set here
        case (s_q.mode)
            fbs_pkg::M_OFFLINE: if (fb_online) s_d.mode = fbs_pkg::M_WAIT;
            fbs_pkg::M_WAIT: if (s_q.cfg_ok && s_q.prm_ok) s_d.mode = fbs_pkg::M_DATAEX;
            fbs_pkg::M_DATAEX: if (!(s_q.cfg_ok && s_q.prm_ok)) s_d.mode = fbs_pkg::M_WAIT;
            default: s_d.mode = fbs_pkg::M_OFFLINE;
        endcase
        if (!fb_online) begin
            s_d.mode = fbs_pkg::M_OFFLINE;
            s_d.cfg_ok = 1'b0; // a new session must configure again
            s_d.prm_ok = 1'b0;
        end
        s_d.dex = (s_d.mode == fbs_pkg::M_DATAEX);

        // station address switches: two-stage sync, clamp digits, tens times ten
        s_d.sw1 = {sw_tens, sw_ones};
        s_d.sw2 = s_q.sw1;
        dt = (s_q.sw2[7:4] > 4'h9) ? 4'h9 : s_q.sw2[7:4];
        do1 = (s_q.sw2[3:0] > 4'h9) ? 4'h9 : s_q.sw2[3:0];
        s_d.addr = {dt, 3'b000} + {2'b00, dt, 1'b0} + {3'b000, do1};

        // network led with a shared flash timebase
        if (s_q.led_cnt == 24'(LED_HALF_CYC - 1)) begin
            s_d.led_cnt = '0;
            s_d.blink = !s_q.blink;
        end else begin
            s_d.led_cnt = s_q.led_cnt + 24'h000001;
        end
        s_d.red = fb_error && s_q.blink;
        s_d.grn = !fb_error && ((s_q.mode == fbs_pkg::M_DATAEX)
            || (s_q.mode == fbs_pkg::M_WAIT && s_q.blink));

        // latest core sample and one-second tick
        if (core_valid) begin
            s_d.lvel = core_vel;
            s_d.ltmp = core_temp;
        end
        s_d.tick = (s_q.tick == 26'(TICK_CYC - 1)) ? '0 : s_q.tick + 26'h0000001;

        // moving mean over the last avg seconds, serial divide by the fill count
        case (s_q.ast)
            fbs_pkg::A_IDLE: begin
                if (s_q.avg == 8'h00) begin
                    s_d.avel = s_q.lvel; // window 0: no averaging
                    s_d.atmp = s_q.ltmp;
                end else if (s_q.tick == 26'(TICK_CYC - 1)) begin
                    s_d.ast = fbs_pkg::A_UPD;
                end
            end
            fbs_pkg::A_UPD: begin
                nsv = s_q.svel + 39'(s_q.lvel);
                nst = s_q.stmp + 23'($signed(s_q.ltmp));
                if (s_q.fill == s_q.avg[6:0]) begin
                    nsv = nsv - 39'(mem_rdata[47:16]);
                    nst = nst - 23'($signed(mem_rdata[15:0]));
                end else begin
                    s_d.fill = s_q.fill + 7'h01;
                end
                s_d.svel = nsv;
                s_d.stmp = nst;
                s_d.wp = s_q.wp + 7'h01;
                s_d.qv = nsv;
                s_d.tneg = nst[22];
                s_d.qt = nst[22] ? 39'(-nst) : 39'(nst);
                s_d.rv = '0;
                s_d.rt = '0;
                s_d.step = fbs_pkg::DIV_STEPS;
                s_d.ast = fbs_pkg::A_DIV;
            end
            fbs_pkg::A_DIV: begin
                if (s_q.step == 6'h00) begin
                    s_d.avel = s_q.qv[31:0];
                    s_d.atmp = s_q.tneg ? 16'(-s_q.qt) : s_q.qt[15:0];
                    s_d.ast = fbs_pkg::A_IDLE;
                end else begin
                    tv = {s_q.rv[6:0], s_q.qv[38]};
                    tt = {s_q.rt[6:0], s_q.qt[38]};
                    s_d.rv = (tv >= {1'b0, s_q.fill}) ? tv - {1'b0, s_q.fill} : tv;
                    s_d.rt = (tt >= {1'b0, s_q.fill}) ? tt - {1'b0, s_q.fill} : tt;
                    s_d.qv = {s_q.qv[37:0], tv >= {1'b0, s_q.fill}};
                    s_d.qt = {s_q.qt[37:0], tt >= {1'b0, s_q.fill}};
                    s_d.step = s_q.step - 6'h01;
                end
            end
            default: s_d.ast = fbs_pkg::A_IDLE;
        endcase
        if (restart) begin
            s_d.ast = fbs_pkg::A_IDLE; // new window length starts from empty
            s_d.fill = '0;
            s_d.svel = '0;
            s_d.stmp = '0;
        end

        // reference conditions scale velocity, and so the volume too
        vk = 49'(s_q.avel) * 49'(fbs_pkg::REF_K[s_q.sref[1:0]]);
        s_d.vref = vk[47:16];

        // temperature in tenths of the chosen unit; range limits stay in Celsius
        tf = $signed(s_q.atmp) * fbs_pkg::F_SCALE;
        case (s_q.tunit)
            fbs_pkg::TU_F: s_d.tout = 16'(tf >>> 16) + fbs_pkg::F_OFS;
            fbs_pkg::TU_K: s_d.tout = s_q.atmp + fbs_pkg::K_OFS;
            default: s_d.tout = s_q.atmp;
        endcase

        // status code: lowest set fault wins
        s_d.status = 16'h0000;
        for (int i = 9; i >= 0; i--) begin
            if (core_flags[i]) begin
                s_d.status = 16'(i + 1);
            end
        end

        // telegram byte server
        tel = {s_q.status, s_q.tout, vol, s_q.vref};
        len = (s_q.cfg_id == fbs_pkg::CFG_LONG) ? fbs_pkg::LEN_LONG : fbs_pkg::LEN_SHORT;
        sh = tel << {tel_idx, 3'b000};
        if (tel_rd) begin
            s_d.tack = 1'b1;
            s_d.tdata = (s_q.dex && tel_idx < len) ? sh[95:88] : 8'h00;
        end
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.rdy;
    assign pslverr = s_q.err;
    assign tel_data = s_q.tdata;
    assign tel_ack = s_q.tack;
    assign data_ex = s_q.dex;
    assign prm_err = s_q.prm_err;
    assign station_addr = s_q.addr;
    assign led_green = s_q.grn;
    assign led_red = s_q.red;

endmodule : fbs_top

// ==== rtl/fbs_pkg.sv ====
// package: constants and types of the fieldbus sensor data slave
package fbs_pkg;

    // ********************************
    // clock and timing
    // ********************************
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 1000; // averaging sample step
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int LED_HALF_MS = 250; // about 2 Hz flashing
    localparam int LED_HALF_CYC = CLK_HZ / 1000 * LED_HALF_MS;

    // ********************************
    // register offsets (byte addresses)
    // ********************************
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_PRM0 = 8'h04;
    localparam logic [7:0] OFF_PRM1 = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_DIAG = 8'h10;
    localparam logic [7:0] OFF_TRNG = 8'h14;

    // ********************************
    // configuration and parameter limits
    // ********************************
    localparam logic [7:0] CFG_LONG = 8'h1B;
    localparam logic [7:0] CFG_SHORT = 8'h17;
    localparam logic [3:0] LEN_LONG = 4'hC;
    localparam logic [3:0] LEN_SHORT = 4'h8;
    localparam logic [7:0] AVG_MAX = 8'h78;
    localparam logic [15:0] DIAM_MIN = 16'h000F;
    localparam logic [15:0] DIAM_MAX = 16'h1388;
    localparam logic [7:0] VUNIT_CNT = 8'h0C;
    localparam logic [7:0] SREF_CNT = 8'h04;
    localparam logic [7:0] TUNIT_CNT = 8'h03;
    localparam logic [7:0] TU_F = 8'h01;
    localparam logic [7:0] TU_K = 8'h02;
    localparam logic [15:0] TEMP_LO_DEF = 16'hFF38; // -20.0 C
    localparam logic [15:0] TEMP_HI_DEF = 16'h0578; // 140.0 C

    // ********************************
    // arithmetic constants
    // ********************************
    localparam logic signed [17:0] F_SCALE = 18'sh1CCCB; // 9/5 in Q16
    localparam logic [15:0] F_OFS = 16'h0140; // 32.0 F in tenths
    localparam logic [15:0] K_OFS = 16'h0AAC; // 273.2 K in tenths
    // reference-condition velocity factors, Q16, index 3..0
    localparam logic [3:0][16:0] REF_K = {17'h0EE89, 17'h0FBA2, 17'h10364, 17'h10000};
    // unit factor = pi/4 * conversion from mm3/s, mantissa Q16 and power of two
    localparam logic [11:0][15:0] VU_MANT = {16'hCDE3, 16'hC105, 16'hB4F5, 16'hEE41,
        16'hDF5D, 16'hD167, 16'hD2D4, 16'hC5A7, 16'hB94C, 16'hD7E3, 16'hCA64, 16'hBDBE};
    localparam logic [11:0][7:0] VU_EXP = {8'hF6, 8'hFC, 8'h02, 8'hE7, 8'hED, 8'hF3,
        8'hEC, 8'hF2, 8'hF8, 8'hE2, 8'hE8, 8'hEE};
    localparam logic [16:0] PROFILE_DEF = 17'h10000; // profile factor 1.0, Q16
    localparam int AVG_AW = 7;
    localparam logic [5:0] DIV_STEPS = 6'h27;

    // ********************************
    // state encodings
    // ********************************
    typedef enum logic [1:0] {
        M_OFFLINE = 2'b00,
        M_WAIT = 2'b01,
        M_DATAEX = 2'b10
    } fbs_mode_t;

    typedef enum logic [1:0] {
        A_IDLE = 2'b00,
        A_UPD = 2'b01,
        A_DIV = 2'b10
    } fbs_avg_t;

endpackage : fbs_pkg

// ==== rtl/fbs_avg_mem.sv ====
// one-second sample ring for the moving average, registered read
`timescale 1ns/1ps
module fbs_avg_mem #(
    parameter int W = 48,
    parameter int AW = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata_q
);

    logic [W-1:0] mem [2**AW];

    // storage write, no reset on the array
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data comes out of a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

endmodule : fbs_avg_mem

// ==== rtl/fbs_volume.sv ====
// volume flow from velocity and pipe diameter, packed as a 32-bit float
`timescale 1ns/1ps
module fbs_volume #(
    parameter logic [16:0] PROFILE_Q16 = fbs_pkg::PROFILE_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] vel,
    input wire logic [15:0] diam,
    input wire logic [3:0] unit,
    output logic [31:0] vol_q
);

    typedef struct packed {
        logic [31:0] vol;
    } fbs_vol_t;

    fbs_vol_t s_q;
    fbs_vol_t s_d;

    function automatic logic [5:0] fbs_msb(input logic [56:0] v);
        logic [5:0] m;
        m = '0;
        for (int i = 0; i < 57; i++) begin
            if (v[i]) begin
                m = 6'(i);
            end
        end
        return m;
    endfunction : fbs_msb

    // area times velocity, scaled by unit and profile factor, then normalised
    always_comb begin
        logic [31:0] d2;
        logic [56:0] x;
        logic [56:0] xs;
        logic [56:0] prod;
        logic [56:0] ps;
        logic [5:0] n;
        logic [5:0] m2;
        int eb;
        d2 = 32'(diam) * 32'(diam);
        x = 57'(vel) * 57'(d2[24:0]);
        n = fbs_msb(x);
        xs = x << (6'd56 - n);
        prod = 57'(xs[56:33]) * 57'(fbs_pkg::VU_MANT[unit]) * 57'(PROFILE_Q16);
        m2 = fbs_msb(prod);
        ps = prod << (6'd56 - m2);
        eb = int'(m2) + int'(n) + int'($signed(fbs_pkg::VU_EXP[unit])) + 72;
        s_d = s_q;
        if (x == '0 || eb <= 0) begin
            s_d.vol = '0; // zero flow or underflow
        end else if (eb >= 255) begin
            s_d.vol = 32'h7F800000; // overflow to infinity
        end else begin
            s_d.vol = {1'b0, 8'(eb), ps[55:33]};
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign vol_q = s_q.vol;

endmodule : fbs_volume

// ==== sim/fbs_chk.sv ====
// checker: port-level properties of the fieldbus sensor data slave
`timescale 1ns/1ps
module fbs_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fb_online,
    input wire logic fb_error,
    input wire logic tel_rd,
    input wire logic [7:0] tel_data,
    input wire logic tel_ack,
    input wire logic data_ex,
    input wire logic prm_err,
    input wire logic [6:0] station_addr,
    input wire logic led_green,
    input wire logic led_red
);
    // ********************************
    // properties
    // ********************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bus answer, telegram handshake, exchange state and led
    AST_APB_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");
    AST_UNMAPPED: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_TEL_ACK: assert property (tel_rd |=> tel_ack)
        else $error("telegram request not acknowledged");
    AST_NO_STRAY_ACK: assert property (!tel_rd |=> !tel_ack)
        else $error("acknowledge without request");
    AST_REFUSE_IDLE: assert property (tel_rd && !data_ex |=> tel_data == 8'h00)
        else $error("telegram data outside exchange");
    AST_DATAEX_DROP: assert property (!fb_online [*2] |-> !data_ex)
        else $error("exchange while link down");
    AST_DIAG_BIT: assert property (pready && !pwrite && paddr == 8'h10 |-> prdata[7:0] == {7'h00, prm_err})
        else $error("error octet mismatch");
    AST_LED_OFF: assert property ((!fb_online && !fb_error) [*4] |-> !led_green && !led_red)
        else $error("led lit while offline");
    AST_LED_ERR: assert property (fb_error [*4] |-> !led_green)
        else $error("green lit during bus error");
    AST_ADDR_RANGE: assert property (station_addr <= 7'h63)
        else $error("station address above range");
endmodule : fbs_chk

bind fbs_top fbs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .fb_online, .fb_error, .tel_rd, .tel_data, .tel_ack, .data_ex, .prm_err, .station_addr, .led_green, .led_red);

// ==== sim/fbs_master_model.sv ====
// partner model: fieldbus master polling the twelve input octets
`timescale 1ns/1ps
module fbs_master_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic slow,
    input wire logic tel_ack,
    input wire logic [7:0] tel_data,
    output logic tel_rd,
    output logic [3:0] tel_idx,
    output logic [95:0] tel,
    output logic done
);
    logic [4:0] sent;
    logic [4:0] got;
    assign done = (got == 5'h0C);
    // requests back to back or with gaps; octets shifted in first to last
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tel_rd <= 0;
            tel_idx <= 4'h0;
            tel <= 96'h0;
            sent <= 5'h0C;
            got <= 5'h0C;
        end else if (start) begin
            sent <= 5'h00;
            got <= 5'h00;
        end else begin
            if (tel_ack) begin
                tel <= {tel[87:0], tel_data};
                got <= got + 5'h01;
            end
            if (sent < 5'h0C && (!slow || !tel_rd)) begin
                tel_rd <= 1;
                tel_idx <= sent[3:0];
                sent <= sent + 5'h01;
            end else begin
                tel_rd <= 0;
                tel_idx <= ~tel_idx;
            end
        end
    end
endmodule : fbs_master_model

// ==== sim/fbs_top_tb.sv ====
// testbench: parameters, telegram, address and led of the sensor data slave
`timescale 1ns/1ps
module fbs_top_tb;
    logic pclk, presetn, psel, penable, pwrite, core_valid, fb_online, fb_error, start, slow, done;
    logic pready, pslverr, tel_rd, tel_ack, data_ex, prm_err, led_green, led_red, err;
    logic [7:0] paddr, tel_data;
    logic [31:0] pwdata, prdata, rd, core_vel;
    logic [3:0] tel_idx, sw_tens, sw_ones;
    logic [15:0] core_temp;
    logic [9:0] core_flags;
    logic [6:0] station_addr;
    logic [95:0] tel, e;
    logic [23:0] lp0, lp1;
    logic [23:0] p0 [12] = '{24'h000F78, 24'h000F79, 24'h138800, 24'h138900, 24'h006400, 24'h000E00,
        24'h006400, 24'h006400, 24'h006400, 24'h006400, 24'h006400, 24'h006400};
    logic [23:0] p1 [12] = '{24'h000000, 24'h000000, 24'h02030B, 24'h000000, 24'h010201, 24'h000000,
        24'h000100, 24'h00000C, 24'h000000, 24'h000400, 24'h020000, 24'h030000};
    int num_errors, total_checks, seed, i, n, r, g;
    fbs_top #(.TICK_CYC(64), .LED_HALF_CYC(8)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .core_valid, .core_temp, .core_vel, .core_flags, .fb_online, .fb_error, .tel_rd,
        .tel_idx, .tel_data, .tel_ack, .data_ex, .prm_err, .sw_tens, .sw_ones, .station_addr, .led_green, .led_red);
    fbs_master_model mst (.pclk, .presetn, .start, .slow, .tel_ack, .tel_data, .tel_rd, .tel_idx, .tel, .done);
    // ********************************
    // clock, watchdog and helpers
    // ********************************
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        #1000000;
        num_errors++;
        end_sim();
    end
    task check(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // one apb transfer, entered just after a rising edge
    task apb(logic w, logic [7:0] a, logic [31:0] d);
        n = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n == 20) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    task prm(logic [23:0] a, logic [23:0] b);
        apb(1, 8'h04, {8'h00, a});
        apb(1, 8'h08, {8'h00, b});
    endtask : prm
    task poll(logic s);
        slow <= s;
        start <= 1;
        @(posedge pclk);
        start <= 0;
        n = 0;
        do begin @(posedge pclk); n++; end while (!done && n < 100);
    endtask : poll
    task leds;
        repeat (2) @(posedge pclk);
        r = 0;
        g = 0;
        repeat (40) begin @(posedge pclk); r += led_red; g += led_green; end
    endtask : leds
    // expected status, temperature and velocity; volume zero
    function logic [95:0] exp_tel(logic [9:0] f, logic [15:0] t, logic [1:0] u, logic [31:0] v);
        logic [15:0] s;
        logic [15:0] tt;
        s = 16'h0000;
        for (int k = 9; k >= 0; k--) if (f[k]) s = 16'(k + 1);
        tt = (u == 2'h0) ? t : (u == 2'h1) ? 16'((int'($signed(t)) * int'(fbs_pkg::F_SCALE)) >>> 16)
            + fbs_pkg::F_OFS : t + fbs_pkg::K_OFS;
        return {s, tt, 32'h0, v};
    endfunction : exp_tel
    task end_sim;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // ********************************
    // main sequence
    // ********************************
    initial begin
        seed = 32'h03EB893F;
        {presetn, psel, penable, pwrite, core_valid, fb_online, fb_error, start, slow} = '0;
        {paddr, pwdata, core_temp, core_vel, core_flags} = '0;
        sw_tens = 4'h9;
        sw_ones = 4'hF;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        check("data_ex_reset", data_ex, 0);
        apb(1, 8'h14, 32'h0);
        apb(0, 8'h14, 32'h0);
        check("temp_range", rd, {fbs_pkg::TEMP_HI_DEF, fbs_pkg::TEMP_LO_DEF});
        apb(0, 8'h20, 32'h0);
        check("slverr", err, 1);
        check("addr_clamp", station_addr, 7'h63);
        $display("test reset done");
        fb_online <= 1;
        apb(1, 8'h00, 32'h1B);
        repeat (4) @(posedge pclk);
        check("data_ex_cfg_only", data_ex, 0);
        for (i = 0; i < 12; i++) begin
            prm(p0[i], p1[i]);
            if (!i[0]) {lp0, lp1} = {p0[i], p1[i]};
            apb(0, 8'h10, 32'h0);
            check("diag_err", rd[7:0], {7'h00, i[0]});
            check("data_ex", data_ex, !i[0]);
            apb(0, 8'h04, 32'h0);
            check("prm0", rd[23:0], lp0);
            apb(0, 8'h08, 32'h0);
            check("prm1", rd[23:0], lp1);
        end
        $display("test parameters done");
        for (i = 0; i < 9; i++) begin
            prm({16'h0064, (i == 8) ? 8'h02 : 8'h00}, {6'h00, 2'(i % 3), 6'h00, 2'(i % 4), 8'h00});
            core_temp <= 16'($random(seed) % 2000);
            core_vel <= (i == 0) ? 32'h0 : $random(seed);
            core_flags <= 10'($random(seed)) & {10{i[0]}};
            core_valid <= 1;
            @(posedge pclk);
            core_valid <= 0;
            repeat ((i == 8) ? 250 : 6) @(posedge pclk);
            poll(i[1]);
            e = exp_tel(core_flags, core_temp, 2'(i % 3), 32'((64'(core_vel) * fbs_pkg::REF_K[i % 4]) >> 16));
            check("status_temp", tel[95:64], e[95:64]);
            check("velocity", tel[31:0], e[31:0]);
            if (i == 0) check("zero_volume", tel[63:32], 32'h0);
        end
        apb(1, 8'h00, 32'h17);
        poll(0);
        check("short_tail", tel[31:0], 32'h0);
        $display("test telegram done");
        for (i = 0; i < 6; i++) begin
            sw_tens <= 4'($random(seed));
            sw_ones <= 4'($random(seed));
            repeat (5) @(posedge pclk);
            check("station_addr", station_addr, (sw_tens > 9 ? 9 : sw_tens) * 10 + (sw_ones > 9 ? 9 : sw_ones));
        end
        fb_error <= 1;
        leds();
        check("red_flash", {r > 10, r < 30, g == 0}, 3'h7);
        fb_error <= 0;
        fb_online <= 0;
        repeat (4) @(posedge pclk);
        poll(0);
        check("offline_tel", tel[95:64] | tel[63:32] | tel[31:0], 32'h0);
        check("offline_led", {led_green, led_red, data_ex}, 3'h0);
        fb_online <= 1;
        leds();
        check("green_flash", {g > 10, g < 30, r == 0}, 3'h7);
        $display("test address and led done");
        end_sim();
    end
endmodule : fbs_top_tb
